// ===== bench/ebw_mem_model.sv
// Purpose: external memory answering on the ready pin
// Assumes: mode 0 prompt, 1 status looped, 2 slow, 3 never ready
// Notes: slow mode frees ready SLOW clocks after status ends
module ebw_mem_model #(parameter int SLOW = 2) (
  input wire logic ref_clk,
  input wire logic [1:0] mode,
  input wire logic sts_n_pin,
  input wire logic mclk_pin,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_r;
  int cnt;
  // Busy from status low until SLOW machine clocks after it ends
  always @(posedge ref_clk)
  begin
    mclk_r <= mclk_pin;
    if (sts_n_pin !== 1'b1)
      cnt <= 0;
    else if (mclk_pin && !mclk_r && cnt <= SLOW)
      cnt <= cnt + 1;
  end
  // Looping the status pin back costs exactly one extra wait
  assign ready = mode == 2'h0 ? 1'b1 :
    mode == 2'h1 ? sts_n_pin :
    mode == 2'h2 ? cnt > SLOW : 1'b0;
endmodule : ebw_mem_model

// ===== bench/ebw_status_assertions.sv
// Purpose: timing checks on the wait-state status pins
// Assumes: wait_cfg and access_fetch held while access_req is high
// Notes: pins judged on their _o and _oe ports
module ebw_status_assertions #(parameter int MC_DIV = 4) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic access_req,
  input wire logic access_fetch,
  input wire logic [2:0] wait_cfg,
  input wire logic off_n_in,
  input wire logic access_done,
  input wire logic microstate_done_n_o,
  input wire logic microstate_done_n_oe,
  input wire logic instr_fetch_flag_n_o,
  input wire logic instr_fetch_flag_n_oe,
  input wire logic machine_clock_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic [5:0] low_r;
  // Length of the current status-low stretch
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      low_r <= 6'h00;
    else
      low_r <= microstate_done_n_o ? 6'h00 : low_r + 6'h01;
  AST_OFF_STS: assert property (
    !off_n_in [*6] |-> !microstate_done_n_oe)
    else $error("status pin driven while off");
  AST_ON_STS: assert property (
    off_n_in [*8] |-> microstate_done_n_oe)
    else $error("status pin not driven");
  AST_OFF_FET: assert property (
    !off_n_in [*6] |-> !instr_fetch_flag_n_oe)
    else $error("fetch flag driven while off");
  AST_MCLK_PER: assert property (
    $rose(machine_clock_out_o) |-> ##MC_DIV $rose(machine_clock_out_o))
    else $error("machine clock period wrong");
  AST_STS_LEN: assert property (
    $rose(microstate_done_n_o) |->
      low_r == (int'(wait_cfg) - 1) * MC_DIV)
    else $error("status low length wrong");
  AST_STS_TWO: assert property (
    $fell(microstate_done_n_o) |-> access_req && wait_cfg >= 3'h2)
    else $error("status low without two waits");
  AST_FET_FETCH: assert property (
    $fell(instr_fetch_flag_n_o) |-> access_req && access_fetch)
    else $error("fetch flag low without fetch");
  AST_FET_END: assert property (
    access_done |-> instr_fetch_flag_n_o && microstate_done_n_o)
    else $error("pins not idle at access end");
endmodule : ebw_status_assertions
bind ebw_status ebw_status_assertions #(.MC_DIV(MC_DIV)) chk_u (
  .ref_clk, .rst, .access_req, .access_fetch, .wait_cfg, .off_n_in,
  .access_done, .microstate_done_n_o, .microstate_done_n_oe,
  .instr_fetch_flag_n_o, .instr_fetch_flag_n_oe, .machine_clock_out_o);

// ===== bench/tb_top.sv
// Purpose: self-checking bench for the wait-state status block
// Assumes: machine cycle of four ref_clk cycles
// Notes: pins resolve to z while their enable is low
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic fetch = 1'b0;
  logic [2:0] ws = 3'h0;
  logic off_n = 1'b1;
  logic [1:0] mode = 2'h0;
  logic ready, done, sts_n_o, sts_oe, fet_n_o, fet_oe, mck_o, mck_oe;
  wire sts_n = sts_oe ? sts_n_o : 1'bz;
  wire fet_n = fet_oe ? fet_n_o : 1'bz;
  wire mck = mck_oe ? mck_o : 1'bz;
  int errors = 0;
  int checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  ebw_status dut_u (.ref_clk(ref_clk), .rst(rst), .access_req(req),
    .access_fetch(fetch), .wait_cfg(ws), .ready_in(ready),
    .off_n_in(off_n), .access_done(done), .microstate_done_n_o(sts_n_o),
    .microstate_done_n_oe(sts_oe), .instr_fetch_flag_n_o(fet_n_o),
    .instr_fetch_flag_n_oe(fet_oe), .machine_clock_out_o(mck_o),
    .machine_clock_out_oe(mck_oe));
  ebw_mem_model mem_u (.ref_clk(ref_clk), .mode(mode), .sts_n_pin(sts_n),
    .mclk_pin(mck), .ready(ready));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One access; fetch-flag low time is (n + 1 + extra) machine cycles
  task automatic run(logic f, logic [2:0] n, logic [1:0] m, int ex);
    int low;
    logic ms;
    low = 0;
    ms = 1'b0;
    mode = m;
    fetch = f;
    ws = n;
    req = 1'b1;
    for (int k = 0; k < 300 && done !== 1'b1; k++)
    begin
      @(negedge ref_clk);
      low += fet_n === 1'b0;
      ms |= sts_n === 1'b0;
    end
    req = 1'b0;
    chk(8'(low), f ? 8'((n + 1 + ex) * 4) : 8'h00);
    chk(ms, n >= 3'h2);
    // Request stays low one cycle so the next call is a fresh edge
    @(negedge ref_clk);
  endtask : run
  task automatic t_mclk;
    time t0;
    @(posedge mck);
    t0 = $time;
    @(posedge mck);
    chk(8'(($time - t0) / 10), 8'h04);
    @(negedge ref_clk);
    $display("machine clock done");
  endtask : t_mclk
  task automatic t_off;
    off_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk(sts_n, 1'bz);
    chk(fet_n, 1'bz);
    chk(mck, 1'bz);
    off_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({fet_n, sts_n}, 2'h3);
    $display("output off done");
  endtask : t_off
  task automatic t_waits;
    for (int n = 0; n < 8; n++)
      run(1'b1, 3'(n), 2'h0, 0);
    $display("wait counts done");
  endtask : t_waits
  task automatic t_data;
    run(1'b0, 3'h3, 2'h0, 0);
    $display("data access done");
  endtask : t_data
  task automatic t_loop;
    run(1'b1, 3'h2, 2'h1, 1);
    run(1'b1, 3'h5, 2'h1, 1);
    $display("looped status done");
  endtask : t_loop
  task automatic t_slow;
    run(1'b1, 3'h3, 2'h2, 3);
    $display("slow device done");
  endtask : t_slow
  task automatic t_ignore;
    run(1'b1, 3'h1, 2'h3, 0);
    run(1'b1, 3'h0, 2'h3, 0);
    $display("ready ignored done");
  endtask : t_ignore
  task automatic report_and_stop;
    $display("checks %0d bad %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Whole run needs far fewer than 10000 ref_clk cycles
  initial
  begin
    #100us;
    errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    t_mclk;
    t_off;
    t_waits;
    t_data;
    t_loop;
    t_slow;
    t_ignore;
    report_and_stop;
  end
endmodule : tb_top

// ===== hw/ebw_cfg.svh
// Purpose: constants for the external bus wait-state status block
// Assumes: 100 MHz ref_clk, machine cycle derived by a divider
// Notes: definitions only
`ifndef EBW_CFG_SVH
`define EBW_CFG_SVH
// Machine cycle length in ref_clk cycles (even, at least 2)
`define EBW_MC_DIV 4
// Least wait-state count at which the status pin and ready apply
`define EBW_MIN_WS 3'h2
// Reset value of the wait-state count
`define EBW_WS_RST 3'h0
`endif

// ===== hw/ebw_pkg.sv
// Purpose: types for the external bus wait-state status block
// Assumes: constants come from ebw_cfg.svh
// Notes: none
package ebw_pkg;
  // Bus cycle phases, one step per machine cycle
  typedef enum logic [1:0]
  {
    EBW_IDLE = 2'b00,
    EBW_SWWAIT = 2'b01,
    EBW_RDYWAIT = 2'b10,
    EBW_DONE = 2'b11
  } ebw_state_t;
endpackage : ebw_pkg

// ===== hw/ebw_status.sv
// Purpose: wait-state status pins and machine clock output of the
//   external memory interface
// Assumes: one access request per machine cycle from core logic;
//   ready and output-off arrive from pins and are synchronised here
// Notes: pins are two signals each; the bench resolves the wire
`include "ebw_cfg.svh"

// Functional notes
// - Status goes low at first wait state, given two or more waits.
// - Status returns high at last wait state.
// - Status looped to ready adds one wait.
// - Status pin floats while output-off low.
// - Fetch flag low during instruction-fetch cycles.
// - Fetch flag floats while output-off low.
// - Machine clock rises bounding each machine cycle.
// - Ready sampled after wait states, retried.
// - Ready ignored with fewer than two waits.
module ebw_status #(
  parameter int MC_DIV = `EBW_MC_DIV
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic access_req,
  input wire logic access_fetch,
  input wire logic [2:0] wait_cfg,
  input wire logic ready_in,
  input wire logic off_n_in,
  output logic access_done,
  output logic microstate_done_n_o,
  output logic microstate_done_n_oe,
  output logic instr_fetch_flag_n_o,
  output logic instr_fetch_flag_n_oe,
  output logic machine_clock_out_o,
  output logic machine_clock_out_oe
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] rdy_sync_r;
  logic [2:0] off_sync_r;
  logic rdy_r;
  logic off_n_r;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdy_sync_r <= 3'h0;
      off_sync_r <= 3'h7;
    end
    else
    begin
      rdy_sync_r <= {rdy_sync_r[1:0], ready_in};
      off_sync_r <= {off_sync_r[1:0], off_n_in};
    end
  end

  // Filtered levels hold their last value while stages disagree
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdy_r <= 1'b0;
      off_n_r <= 1'b1;
    end
    else
    begin
      if (rdy_sync_r[1] == rdy_sync_r[2])
        rdy_r <= rdy_sync_r[2];
      if (off_sync_r[1] == off_sync_r[2])
        off_n_r <= off_sync_r[2];
    end
  end

  // ---------------------------------------------------------------
  // Machine cycle divider
  // ---------------------------------------------------------------
  localparam int DW = $clog2(MC_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(MC_DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(MC_DIV / 2 - 1);
  logic [DW-1:0] div_r;
  logic mc_tick;

  // Tick marks the boundary between machine cycles
  assign mc_tick = (div_r == DIV_LAST);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      div_r <= '0;
    else if (mc_tick)
      div_r <= '0;
    else
      div_r <= div_r + DW'(1);
  end

  // Output rises as each machine cycle starts, falls halfway
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      machine_clock_out_o <= 1'b0;
    else if (mc_tick)
      machine_clock_out_o <= 1'b1;
    else if (div_r == DIV_HALF)
      machine_clock_out_o <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Access sequencer, advanced once per machine cycle
  // ---------------------------------------------------------------
  ebw_pkg::ebw_state_t state_r;
  logic [2:0] ws_left_r;
  logic use_ready_r;
  logic fetch_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ebw_pkg::EBW_IDLE;
      ws_left_r <= `EBW_WS_RST;
      use_ready_r <= 1'b0;
      fetch_r <= 1'b0;
    end
    else if (mc_tick)
    begin
      case (state_r)
        ebw_pkg::EBW_IDLE:
        begin
          if (access_req)
          begin
            fetch_r <= access_fetch;
            ws_left_r <= wait_cfg;
            use_ready_r <= (wait_cfg >= `EBW_MIN_WS);
            state_r <= (wait_cfg == 3'h0) ? ebw_pkg::EBW_DONE
                                          : ebw_pkg::EBW_SWWAIT;
          end
        end
        ebw_pkg::EBW_SWWAIT:
        begin
          ws_left_r <= ws_left_r - 3'h1;
          // Ready first looked at as the last software wait ends; a
          // high ready adds nothing, so only a low one costs a wait
          if (ws_left_r == 3'h1)
          begin
            if (use_ready_r && !rdy_r)
              state_r <= ebw_pkg::EBW_RDYWAIT;
            else
              state_r <= ebw_pkg::EBW_DONE;
          end
        end
        ebw_pkg::EBW_RDYWAIT:
        begin
          // Each low sample costs one more machine cycle and a resample
          if (rdy_r)
            state_r <= ebw_pkg::EBW_DONE;
        end
        ebw_pkg::EBW_DONE:
        begin
          fetch_r <= 1'b0;
          state_r <= ebw_pkg::EBW_IDLE;
        end
        default:
          state_r <= ebw_pkg::EBW_IDLE;
      endcase
    end
  end

  // One ref_clk pulse as the access finishes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      access_done <= 1'b0;
    else
      access_done <= mc_tick && (state_r == ebw_pkg::EBW_DONE);
  end

  // ---------------------------------------------------------------
  // Status pins
  // ---------------------------------------------------------------
  logic done_n_nxt;
  logic fetch_n_nxt;

  // Low from the first wait state until the last one starts; a
  // looped-back ready thus returns high one cycle before the last wait ends
  always_comb
  begin
    done_n_nxt = 1'b1;
    if (mc_tick)
    begin
      if (state_r == ebw_pkg::EBW_IDLE && access_req
          && wait_cfg >= `EBW_MIN_WS)
        done_n_nxt = 1'b0;
      else if (state_r == ebw_pkg::EBW_SWWAIT && ws_left_r > 3'h2)
        done_n_nxt = 1'b0;
    end
    else
      done_n_nxt = microstate_done_n_o;
  end

  // Fetch flag low for the whole bus cycle of a fetch
  always_comb
  begin
    fetch_n_nxt = instr_fetch_flag_n_o;
    if (mc_tick)
    begin
      if (state_r == ebw_pkg::EBW_IDLE)
        fetch_n_nxt = !(access_req && access_fetch);
      else if (state_r == ebw_pkg::EBW_DONE)
        fetch_n_nxt = 1'b1;
      else
        fetch_n_nxt = !fetch_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      microstate_done_n_o <= 1'b1;
      instr_fetch_flag_n_o <= 1'b1;
    end
    else
    begin
      microstate_done_n_o <= done_n_nxt;
      instr_fetch_flag_n_o <= fetch_n_nxt;
    end
  end

  // Output-off low floats every status pin
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      microstate_done_n_oe <= 1'b0;
      instr_fetch_flag_n_oe <= 1'b0;
      machine_clock_out_oe <= 1'b0;
    end
    else
    begin
      microstate_done_n_oe <= off_n_r;
      instr_fetch_flag_n_oe <= off_n_r;
      machine_clock_out_oe <= off_n_r;
    end
  end

endmodule : ebw_status
